// ==== hdl/asr_cmp_if.sv ====
// Purpose: Carries one result and window settings to the last-channel comparator
// Assumes: Single clock domain, purely combinational path
// Notes: Width follows the converter result width
`timescale 1ns/1ps
interface asr_cmp_if #(
    parameter int DATA_W = 12
);
    import asr_pkg::*;
    logic [DATA_W-1:0] data; // Result under test
    logic [DATA_W-1:0] low_thres; // Window low edge
    logic [DATA_W-1:0] high_thres; // Window high edge
    asr_cmp_mode_t mode; // Selected comparison
    logic hit; // Result matches the mode

    modport regs (output data, output low_thres, output high_thres, output mode, input hit);
    modport comparator (input data, input low_thres, input high_thres, input mode, output hit);
endinterface

// ==== hdl/asr_lc_compare.sv ====
// Purpose: Window comparison of the last channel's result
// Assumes: Thresholds are inclusive window edges
// Notes: Combinational only, no state
`timescale 1ns/1ps
module asr_lc_compare
    import asr_pkg::*;
(
    asr_cmp_if.comparator cmp
);
    logic below; // Under the low edge
    logic above; // Over the high edge

    // Edge tests
    assign below = (cmp.data < cmp.low_thres);
    assign above = (cmp.data > cmp.high_thres);

    // Mode selects which region raises the event
    always_comb begin
        case (cmp.mode)
            ASR_CMP_LOW: cmp.hit = below;
            ASR_CMP_HIGH: cmp.hit = above;
            ASR_CMP_IN: cmp.hit = !below && !above;
            default: cmp.hit = below || above;
        endcase
    end
endmodule

// ==== hdl/asr_pkg.sv ====
// Purpose: Shared constants for the converter status and interrupt register group
// Assumes: 32-bit register bus, byte addresses, one aligned word per register
// Notes: Field positions are shared by enable, disable, mask and status words
package asr_pkg;
    // Register byte addresses
    localparam logic [31:0] ASR_CHAN_STATUS_ADDR = 32'h4003_8018;
    localparam logic [31:0] ASR_LAST_RESULT_ADDR = 32'h4003_8020;
    localparam logic [31:0] ASR_IRQ_SET_ADDR = 32'h4003_8024;
    localparam logic [31:0] ASR_IRQ_CLEAR_ADDR = 32'h4003_8028;
    localparam logic [31:0] ASR_IRQ_MASK_ADDR = 32'h4003_802C;
    localparam logic [31:0] ASR_IRQ_FLAGS_ADDR = 32'h4003_8030;
    localparam logic [31:0] ASR_LC_TRIG_ADDR = 32'h4003_8034;

    // Status and mask bit positions
    localparam int ASR_DONE_LSB = 0;
    localparam int ASR_LC_CHANGE_BIT = 19;
    localparam int ASR_CALIB_DONE_BIT = 23;
    localparam int ASR_READY_BIT = 24;
    localparam int ASR_OVERRUN_BIT = 25;
    localparam int ASR_COMPARE_BIT = 26;
    localparam int ASR_RX_END_BIT = 27;
    localparam int ASR_RX_FULL_BIT = 28;
    // Bits that exist in the shared layout
    localparam logic [31:0] ASR_IRQ_VALID = 32'h1F88_00FF;

    // Last-result field layout
    localparam int ASR_RESULT_LSB = 0;
    localparam int ASR_CHAN_NUM_LSB = 12;

    // Last-channel trigger mode layout
    localparam int ASR_RTC_TRIG_BIT = 0;
    localparam int ASR_CMP_MODE_LSB = 4;

    // Reset values
    localparam logic [31:0] ASR_MASK_RESET = 32'h0000_0000;
    localparam logic [1:0] ASR_CMP_MODE_RESET = 2'h0;
    localparam logic [31:0] ASR_RDATA_RESET = 32'h0000_0000;

    // Comparison modes
    typedef enum logic [1:0] {
        ASR_CMP_LOW = 2'b00,
        ASR_CMP_HIGH = 2'b01,
        ASR_CMP_IN = 2'b10,
        ASR_CMP_OUT = 2'b11
    } asr_cmp_mode_t;

    // Index of the last channel watched for change
    localparam logic [2:0] ASR_LAST_CHAN = 3'h7;
endpackage

// ==== hdl/asr_status_regs.sv ====
// Purpose: Status, result, mask and last-channel mode registers of the converter
// Assumes: Event inputs are one-cycle pulses synchronous to clk_i
// Notes: Read data appears the cycle after the read strobe, zero when unmapped
//
// Overview of operation
// - Channel status bits mirror channel enables
// - Latch result at every conversion end
// - Channel number shown only when tagging
// - Enable-set write ones set mask bits
// - Enable-clear write ones clear mask bits
// - Mask register reads enabled sources
// - Shared bit layout across irq registers
// - Per-channel done set, cleared by read
// - Last channel change flag, clear-on-read
// - Calibration done after requested sequence
// - Result ready cleared by result read
// - Overrun flag cleared on status read
// - Compare flag cleared on status read
// - Receive end cleared by counter write
// - Trigger mode writes blocked when protected
// - Dual trigger routes last channel trigger
// - Compare mode selects event region
// - Tagging appends channel number to result
`timescale 1ns/1ps
module asr_status_regs
    import asr_pkg::*;
#(
    parameter int NUM_CHAN = 8,
    parameter int DATA_W = 12,
    parameter int CHAN_NUM_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Conversion engine side
    input wire logic [NUM_CHAN-1:0] chan_enabled_bit_i,
    input wire logic conv_done_i,
    input wire logic [2:0] conv_chan_i,
    input wire logic [DATA_W-1:0] conv_data_i,
    input wire logic tag_enable_i,
    input wire logic [NUM_CHAN-1:0] chan_data_read_i,
    input wire logic calib_start_i,
    input wire logic calib_end_i,
    input wire logic overrun_i,
    input wire logic compare_event_i,
    input wire logic [DATA_W-1:0] lc_low_thres_i,
    input wire logic [DATA_W-1:0] lc_high_thres_i,
    // Transfer counter side
    input wire logic receive_counter_hit_zero_i,
    input wire logic receive_counter_write_i,
    input wire logic receive_counter_zero_i,
    input wire logic next_receive_counter_zero_i,
    input wire logic write_protect_on_i,
    // Configuration and mask outputs
    output logic last_chan_rtc_trigger_o,
    output logic [1:0] last_chan_compare_mode_o,
    output logic [31:0] irq_mask_o
);
    // Whole register state
    typedef struct packed {
        logic [31:0] mask; // Interrupt enables
        logic [NUM_CHAN-1:0] conversion_done_flag; // Per-channel done
        logic last_chan_change_flag; // Last channel change
        logic calibration_done_flag; // Calibration finished
        logic calib_running; // Calibration in progress
        logic result_ready_flag; // New result present
        logic general_overrun_flag; // Overrun seen
        logic compare_event_flag; // Compare event seen
        logic receive_end_flag; // Receive counter reached zero
        logic [DATA_W-1:0] last_result_value; // Last result
        logic [CHAN_NUM_W-1:0] result_chan_number; // Tag of last result
        logic last_chan_rtc_trigger; // Dual trigger select
        logic [1:0] last_chan_compare_mode; // Last channel compare mode
        logic [31:0] rdata; // Registered read data
    } asr_state_t;

    asr_state_t s; // Current state
    asr_state_t next_s; // Next state
    logic receive_full_flag; // Both counters empty
    logic lc_hit; // Comparator result

    asr_cmp_if #(.DATA_W(DATA_W)) cmp_bus ();

    // Last-channel comparator wiring
    assign cmp_bus.data = conv_data_i;
    assign cmp_bus.low_thres = lc_low_thres_i;
    assign cmp_bus.high_thres = lc_high_thres_i;
    assign cmp_bus.mode = asr_cmp_mode_t'(s.last_chan_compare_mode);
    assign lc_hit = cmp_bus.hit;

    asr_lc_compare u_lc_compare (
        .cmp(cmp_bus.comparator)
    );

    // Full buffer is a live view of the two counters
    assign receive_full_flag = receive_counter_zero_i && next_receive_counter_zero_i;

    // Places each flag at its shared layout position
    function automatic logic [31:0] pack_flags(input asr_state_t st, input logic full,
                                               input logic [NUM_CHAN-1:0] en);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ASR_DONE_LSB +: NUM_CHAN] = st.conversion_done_flag & en;
        w[ASR_LC_CHANGE_BIT] = st.last_chan_change_flag;
        w[ASR_CALIB_DONE_BIT] = st.calibration_done_flag;
        w[ASR_READY_BIT] = st.result_ready_flag;
        w[ASR_OVERRUN_BIT] = st.general_overrun_flag;
        w[ASR_COMPARE_BIT] = st.compare_event_flag;
        w[ASR_RX_END_BIT] = st.receive_end_flag;
        w[ASR_RX_FULL_BIT] = full;
        return w;
    endfunction

    // Address match helper shared by read and write decode
    function automatic logic hit_addr(input logic [31:0] a, input logic [31:0] reg_addr);
        return a == reg_addr;
    endfunction

    // Next-state logic; clears are applied first so same-cycle sets win
    always_comb begin
        logic status_read; // Status word is being read
        logic result_read; // Last result is being read
        logic [31:0] word; // Read word being assembled
        status_read = 1'b0;
        result_read = 1'b0;
        word = 32'h0000_0000;
        next_s = s;

        // Read decode, returns the value before any read side effect
        if (reg_rd_i) begin
            if (hit_addr(reg_addr_i, ASR_CHAN_STATUS_ADDR)) begin
                word[NUM_CHAN-1:0] = chan_enabled_bit_i;
            end else if (hit_addr(reg_addr_i, ASR_LAST_RESULT_ADDR)) begin
                word[ASR_RESULT_LSB +: DATA_W] = s.last_result_value;
                word[ASR_CHAN_NUM_LSB +: CHAN_NUM_W] = s.result_chan_number;
                result_read = 1'b1;
            end else if (hit_addr(reg_addr_i, ASR_IRQ_MASK_ADDR)) begin
                word = s.mask;
            end else if (hit_addr(reg_addr_i, ASR_IRQ_FLAGS_ADDR)) begin
                word = pack_flags(s, receive_full_flag, chan_enabled_bit_i);
                status_read = 1'b1;
            end else if (hit_addr(reg_addr_i, ASR_LC_TRIG_ADDR)) begin
                word[ASR_RTC_TRIG_BIT] = s.last_chan_rtc_trigger;
                word[ASR_CMP_MODE_LSB +: 2] = s.last_chan_compare_mode;
            end else begin
                // Unmapped and write-only addresses read as zero
                word = 32'h0000_0000;
            end
        end
        next_s.rdata = word;

        // Write decode
        if (reg_wr_i) begin
            if (hit_addr(reg_addr_i, ASR_IRQ_SET_ADDR)) begin
                next_s.mask = s.mask | (reg_wdata_i & ASR_IRQ_VALID);
            end else if (hit_addr(reg_addr_i, ASR_IRQ_CLEAR_ADDR)) begin
                next_s.mask = s.mask & ~(reg_wdata_i & ASR_IRQ_VALID);
            end else if (hit_addr(reg_addr_i, ASR_LC_TRIG_ADDR)) begin
                // Protection drops the write silently
                if (!write_protect_on_i) begin
                    next_s.last_chan_rtc_trigger = reg_wdata_i[ASR_RTC_TRIG_BIT];
                    next_s.last_chan_compare_mode = reg_wdata_i[ASR_CMP_MODE_LSB +: 2];
                end
            end else begin
                // Read-only and unmapped writes are ignored
                next_s.mask = s.mask;
            end
        end

        // Clears from reads and counter writes
        next_s.conversion_done_flag = s.conversion_done_flag & ~chan_data_read_i;
        if (result_read) begin
            next_s.result_ready_flag = 1'b0;
        end
        if (status_read) begin
            next_s.last_chan_change_flag = 1'b0;
            next_s.general_overrun_flag = 1'b0;
            next_s.compare_event_flag = 1'b0;
        end
        if (receive_counter_write_i) begin
            next_s.receive_end_flag = 1'b0;
        end

        // Conversion end loads the result and raises its flags
        if (conv_done_i) begin
            next_s.last_result_value = conv_data_i;
            // Untagged results carry a zero channel field
            next_s.result_chan_number = tag_enable_i ? CHAN_NUM_W'(conv_chan_i) : '0;
            next_s.result_ready_flag = 1'b1;
            if (chan_enabled_bit_i[conv_chan_i]) begin
                next_s.conversion_done_flag[conv_chan_i] = 1'b1;
            end
            if (conv_chan_i == ASR_LAST_CHAN && lc_hit) begin
                next_s.last_chan_change_flag = 1'b1;
            end
        end

        // A disabled channel never holds a done flag
        next_s.conversion_done_flag = next_s.conversion_done_flag & chan_enabled_bit_i;

        // Other sticky events
        if (overrun_i) begin
            next_s.general_overrun_flag = 1'b1;
        end
        if (compare_event_i) begin
            next_s.compare_event_flag = 1'b1;
        end
        if (receive_counter_hit_zero_i) begin
            next_s.receive_end_flag = 1'b1;
        end

        // Calibration: flag low while running, high once finished
        if (calib_start_i) begin
            next_s.calib_running = 1'b1;
            next_s.calibration_done_flag = 1'b0;
        end
        if (calib_end_i && next_s.calib_running) begin
            next_s.calib_running = 1'b0;
            next_s.calibration_done_flag = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
            s.mask <= ASR_MASK_RESET;
            s.last_chan_compare_mode <= ASR_CMP_MODE_RESET;
            s.rdata <= ASR_RDATA_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata_o = s.rdata;
    assign last_chan_rtc_trigger_o = s.last_chan_rtc_trigger;
    assign last_chan_compare_mode_o = s.last_chan_compare_mode;
    assign irq_mask_o = s.mask;
endmodule

// ==== testbench/asr_status_monitor.sv ====
// Purpose: Port checks for the converter status register group
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the register group
`timescale 1ns/1ps
module asr_status_monitor
    import asr_pkg::*;
#(
    parameter int NUM_CHAN = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [NUM_CHAN-1:0] chan_enabled_bit_i,
    input wire logic overrun_i,
    input wire logic receive_counter_zero_i,
    input wire logic next_receive_counter_zero_i,
    input wire logic write_protect_on_i,
    input wire logic last_chan_rtc_trigger_o,
    input wire logic [1:0] last_chan_compare_mode_o,
    input wire logic [31:0] irq_mask_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Strobes aimed at one register
    sequence s_wr(logic [31:0] a); reg_wr_i && reg_addr_i == a; endsequence
    sequence s_rd(logic [31:0] a); reg_rd_i && reg_addr_i == a; endsequence
    mask_set_a: assert property (s_wr(ASR_IRQ_SET_ADDR) |=>
        irq_mask_o == ($past(irq_mask_o) | ($past(reg_wdata_i) & ASR_IRQ_VALID)))
        else $error("mask set write wrong");
    mask_clear_a: assert property (s_wr(ASR_IRQ_CLEAR_ADDR) |=>
        irq_mask_o == ($past(irq_mask_o) & ~($past(reg_wdata_i) & ASR_IRQ_VALID)))
        else $error("mask clear write wrong");
    mask_view_a: assert property (s_rd(ASR_IRQ_MASK_ADDR) |=>
        reg_rdata_o == $past(irq_mask_o)) else $error("mask read wrong");
    chan_view_a: assert property (s_rd(ASR_CHAN_STATUS_ADDR) |=>
        reg_rdata_o == 32'($past(chan_enabled_bit_i))) else $error("channel read wrong");
    reserved_zero_a: assert property (s_rd(ASR_IRQ_FLAGS_ADDR) |=>
        (reg_rdata_o & ~ASR_IRQ_VALID) == 32'h0) else $error("reserved flag bit set");
    rx_full_a: assert property (s_rd(ASR_IRQ_FLAGS_ADDR) |=> reg_rdata_o[ASR_RX_FULL_BIT]
        == $past(receive_counter_zero_i && next_receive_counter_zero_i))
        else $error("buffer full flag wrong");
    trig_lock_a: assert property (s_wr(ASR_LC_TRIG_ADDR) ##0 write_protect_on_i |=>
        $stable(last_chan_compare_mode_o) && $stable(last_chan_rtc_trigger_o))
        else $error("protected trigger write took effect");
    trig_write_a: assert property (s_wr(ASR_LC_TRIG_ADDR) ##0 !write_protect_on_i |=>
        last_chan_rtc_trigger_o == $past(reg_wdata_i[0])
        && last_chan_compare_mode_o == $past(reg_wdata_i[5:4])) else $error("trigger write lost");
    overrun_kept_a: assert property (overrun_i ##1 s_rd(ASR_IRQ_FLAGS_ADDR) |=>
        reg_rdata_o[ASR_OVERRUN_BIT]) else $error("overrun flag missing");
    read_clears_a: assert property (s_rd(ASR_IRQ_FLAGS_ADDR) ##0 !overrun_i ##1 !overrun_i
        ##1 s_rd(ASR_IRQ_FLAGS_ADDR) |=> !reg_rdata_o[ASR_OVERRUN_BIT])
        else $error("overrun flag not cleared by read");
endmodule

bind asr_status_regs asr_status_monitor #(.NUM_CHAN(NUM_CHAN)) u_mon (.clk_i, .rst_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .chan_enabled_bit_i,
    .overrun_i, .receive_counter_zero_i, .next_receive_counter_zero_i, .write_protect_on_i,
    .last_chan_rtc_trigger_o, .last_chan_compare_mode_o, .irq_mask_o);

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the status register group
// Assumes: Bus tasks leave one idle cycle after each strobe
// Notes: Expected words come from a small model kept here
`timescale 1ns/1ps
module tb_top;
    import asr_pkg::*;
    logic clk_i = 1'b0; // 8 ns clock
    logic rst_n_i = 1'b0; // Low for ten cycles
    logic [31:0] reg_addr_i = 32'h0, reg_wdata_i = 32'h0, reg_rdata_o, irq_mask_o;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, tag_enable_i = 1'b0, write_protect_on_i = 1'b0;
    logic receive_counter_zero_i = 1'b0, next_receive_counter_zero_i = 1'b0;
    logic [7:0] chan_enabled_bit_i = 8'h00; // Enable levels
    logic [2:0] conv_chan_i = 3'h0;
    logic [11:0] conv_data_i = 12'h000, lc_low_thres_i = 12'h064, lc_high_thres_i = 12'h0C8;
    logic [14:0] ev = 15'h0; // Event pulses, channel reads on top
    logic last_chan_rtc_trigger_o;
    logic [1:0] last_chan_compare_mode_o;
    logic [31:0] m_mask = 32'h0, m_flags = 32'h0, m_last = 32'h0, seed = 32'h0001_624D;
    int errors = 0, checks = 0, i, m_mode = 0;
    int vals[4] = '{99, 100, 200, 201}; // Window edges and their neighbours

    always #4 clk_i = ~clk_i; // Half period

    asr_status_regs DUT (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .chan_enabled_bit_i, .conv_done_i(ev[0]), .conv_chan_i, .conv_data_i,
        .tag_enable_i, .chan_data_read_i(ev[14:7]), .calib_start_i(ev[1]), .calib_end_i(ev[2]),
        .overrun_i(ev[3]), .compare_event_i(ev[4]), .lc_low_thres_i, .lc_high_thres_i,
        .receive_counter_hit_zero_i(ev[5]), .receive_counter_write_i(ev[6]),
        .receive_counter_zero_i, .next_receive_counter_zero_i, .write_protect_on_i,
        .last_chan_rtc_trigger_o, .last_chan_compare_mode_o, .irq_mask_o);

    // Shift register source of random words
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Does a last-channel result raise an event in mode m
    function automatic bit hit(input int m, input int d);
        int lo = lc_low_thres_i;
        int hi = lc_high_thres_i;
        case (m)
            0: return d < lo;
            1: return d > hi;
            2: return d >= lo && d <= hi;
            default: return d < lo || d > hi;
        endcase
    endfunction
    // Expected flag word, buffer full is a live level
    function automatic logic [31:0] flags();
        return m_flags | {3'h0, receive_counter_zero_i & next_receive_counter_zero_i, 28'h0};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One write cycle, model follows the mask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        if (a == ASR_IRQ_SET_ADDR) m_mask |= d & ASR_IRQ_VALID;
        if (a == ASR_IRQ_CLEAR_ADDR) m_mask &= ~(d & ASR_IRQ_VALID);
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Read, compare, then apply clear-on-read to the model
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        ev <= 15'h0; // Ends an event raised beside the read
        #1 chk($sformatf("read %h", a), reg_rdata_o, e);
        if (a == ASR_IRQ_FLAGS_ADDR) m_flags &= ~32'h0608_0000;
        if (a == ASR_LAST_RESULT_ADDR) m_flags[ASR_READY_BIT] = 1'b0;
        @(posedge clk_i);
    endtask
    // One-cycle event pulse, then an idle cycle
    task automatic pulse(input logic [14:0] p);
        ev <= p;
        @(posedge clk_i);
        ev <= 15'h0;
        @(posedge clk_i);
    endtask
    // Conversion end; tag is captured with the result
    task automatic conv(input logic [2:0] c, input int d);
        conv_chan_i <= c;
        conv_data_i <= 12'(d);
        m_last = {16'h0, tag_enable_i ? {1'b0, c} : 4'h0, 12'(d)};
        m_flags[ASR_READY_BIT] = 1'b1;
        if (chan_enabled_bit_i[c]) m_flags[c] = 1'b1;
        if (c == ASR_LAST_CHAN && hit(m_mode, d)) m_flags[ASR_LC_CHANGE_BIT] = 1'b1;
        pulse(15'h1);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        results();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        chk("reset outputs", irq_mask_o | reg_rdata_o
            | 32'({last_chan_compare_mode_o, last_chan_rtc_trigger_o}), 32'h0);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            wr(seed[0] ? ASR_IRQ_SET_ADDR : ASR_IRQ_CLEAR_ADDR, seed);
            rdc(ASR_IRQ_MASK_ADDR, m_mask);
        end
        wr(ASR_IRQ_MASK_ADDR, 32'hFFFF_FFFF); // Read-only place ignores writes
        rdc(ASR_IRQ_MASK_ADDR, m_mask);
        rdc(32'h4003_801C, 32'h0);
        chan_enabled_bit_i <= {1'b1, seed[6:4], 1'b1, seed[2:1], 1'b0};
        write_protect_on_i <= 1'b1;
        wr(ASR_LC_TRIG_ADDR, 32'h0000_0031);
        chk("locked mode", 32'({last_chan_compare_mode_o, last_chan_rtc_trigger_o}), 32'h0);
        write_protect_on_i <= 1'b0;
        rdc(ASR_CHAN_STATUS_ADDR, {24'h0, chan_enabled_bit_i});
        for (m_mode = 0; m_mode < 4; m_mode++) begin
            tag_enable_i <= m_mode[0];
            wr(ASR_LC_TRIG_ADDR, 32'(m_mode * 16 + m_mode % 2));
            chk("mode", 32'({last_chan_compare_mode_o, last_chan_rtc_trigger_o}),
                32'(m_mode * 2 + m_mode % 2));
            for (i = 0; i < 4; i++) begin
                conv(ASR_LAST_CHAN, vals[i]);
                rdc(ASR_IRQ_FLAGS_ADDR, flags());
                rdc(ASR_LAST_RESULT_ADDR, m_last);
            end
        end
        conv(3'h0, 291); // Disabled channel sets no done flag
        conv(3'h3, 1110);
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        pulse({8'h88, 7'h0}); // Software reads channels 3 and 7
        m_flags &= ~32'h0000_0088;
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        ev <= 15'h0018; // Overrun and compare just before a read
        @(posedge clk_i);
        ev <= 15'h0;
        m_flags |= 32'h0600_0000;
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        ev <= 15'h0008; // Overrun lands in the very cycle of a status read
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        m_flags[ASR_OVERRUN_BIT] = 1'b1;
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        pulse(15'h0004); // End without a request is ignored
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        pulse(15'h0002);
        pulse(15'h0004);
        m_flags[ASR_CALIB_DONE_BIT] = 1'b1;
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        pulse(15'h0002); // New request drops the done flag
        m_flags[ASR_CALIB_DONE_BIT] = 1'b0;
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        pulse(15'h0020); // Receive counter reached zero
        m_flags[ASR_RX_END_BIT] = 1'b1;
        rdc(ASR_IRQ_FLAGS_ADDR, flags());
        pulse(15'h0040); // Counter write clears the end flag
        m_flags[ASR_RX_END_BIT] = 1'b0;
        for (i = 0; i < 4; i++) begin
            {receive_counter_zero_i, next_receive_counter_zero_i} <= 2'(i);
            @(posedge clk_i);
            rdc(ASR_IRQ_FLAGS_ADDR, flags());
        end
        results();
    end
endmodule
